/* File: bench/dabc_chk_sva.sv */
// Checker for the status read path and breakpoint control access answers.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dabc_chk_sva #(
	parameter NUM_BKPT    = 16,
	parameter NSI_PRESENT = 1
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        accValid,
	input wire logic        accWrite,
	input wire logic [3:0]  accCrn,
	input wire logic [3:0]  accCrm,
	input wire logic [2:0]  accOp2,
	input wire logic [1:0]  curLevel,
	input wire logic        level2Enabled,
	input wire logic        haveLevel3,
	input wire logic [1:0]  level2_debug_trap_pair,
	input wire logic        level3_debug_access_trap,
	input wire logic        coreHalted,
	input wire logic        secure_debug_disabled,
	input wire logic        extInvasiveEnabled,
	input wire logic        accDone,
	input wire logic [1:0]  accResp,
	input wire logic [5:0]  accClass,
	input wire logic [63:0] accRdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Decoded status read, halted undefined case, expected status field
	wire       au  = accValid && !accWrite && accCrn == 4'h7 && accCrm == 4'hE && accOp2 == 3'h6;
	wire       hsd = coreHalted && secure_debug_disabled && level3_debug_access_trap;
	wire [1:0] nsi = NSI_PRESENT == 0 ? 2'h0 : {1'b1, extInvasiveEnabled};
	property p_l0; au && curLevel == 2'h0 |=> accDone && accResp == 2'h1; endproperty
	a_l0: assert property (p_l0) else $error("level 0 read not undefined");
	property p_pair; au && curLevel == 2'h1 && !(hsd && haveLevel3) && level2Enabled
		&& level2_debug_trap_pair != 2'h0 |=> accResp == 2'h2 && accClass == 6'h18; endproperty
	a_pair: assert property (p_pair) else $error("level 2 trap missing");
	property p_l3; au && curLevel == 2'h2 && haveLevel3 && level3_debug_access_trap
		&& !(coreHalted && secure_debug_disabled) |=> accResp == 2'h3 && accClass == 6'h18; endproperty
	a_l3: assert property (p_l3) else $error("level 3 trap missing");
	property p_hsd; au && (curLevel == 2'h1 || curLevel == 2'h2) && hsd && haveLevel3 |=> accResp == 2'h1;
	endproperty
	a_hsd: assert property (p_hsd) else $error("halted case not undefined");
	property p_rd; au && curLevel == 2'h3 && !hsd |=> accResp == 2'h0 && accRdata == {62'h0, $past(nsi)};
	endproperty
	a_rd: assert property (p_rd) else $error("status read value wrong");
	property p_hi; accDone |-> accRdata[63:32] == 32'h0 && accClass != 6'h18 || accResp[1]; endproperty
	a_hi: assert property (p_hi) else $error("upper half or class wrong");
	property p_idx; accValid && accCrn == 4'h0 && accOp2 == 3'h5 && curLevel == 2'h3
		&& accCrm >= NUM_BKPT |=> accDone && accResp == 2'h1; endproperty
	a_idx: assert property (p_idx) else $error("missing breakpoint not undefined");
	property p_ans; accValid |=> accDone; endproperty
	a_ans: assert property (p_ans) else $error("access not answered");
	c_t3: cover property (au && curLevel == 2'h2 ##1 accResp == 2'h3);
	c_un: cover property (au && curLevel == 2'h0 ##1 accResp == 2'h1);
	c_ok: cover property (au && curLevel == 2'h3 ##1 accResp == 2'h0);
endmodule
bind dabc_debug_auth_bkpt dabc_chk_sva #(.NUM_BKPT(NUM_BKPT), .NSI_PRESENT(NSI_PRESENT)) i_dabc_chk_sva (
	.clk(clk), .rst_n(rst_n), .accValid(accValid), .accWrite(accWrite), .accCrn(accCrn), .accCrm(accCrm),
	.accOp2(accOp2), .curLevel(curLevel), .level2Enabled(level2Enabled), .haveLevel3(haveLevel3),
	.level2_debug_trap_pair(level2_debug_trap_pair), .level3_debug_access_trap(level3_debug_access_trap),
	.coreHalted(coreHalted), .secure_debug_disabled(secure_debug_disabled),
	.extInvasiveEnabled(extInvasiveEnabled), .accDone(accDone), .accResp(accResp), .accClass(accClass),
	.accRdata(accRdata));
`default_nettype wire

/* File: bench/dabc_core_model.sv */
// Core model issuing decoded system-register accesses.
// Assumes the caller waits for the answer before the next access.
`timescale 1ns/1ps
`default_nettype none
module dabc_core_model (
	input  wire logic        clk,
	output logic        accValid,
	output logic        accWrite,
	output logic [1:0]  accOp0,
	output logic [2:0]  accOp1,
	output logic [3:0]  accCrn,
	output logic [3:0]  accCrm,
	output logic [2:0]  accOp2,
	output logic [63:0] accWdata
);
	// Idle port
	initial begin
		accValid = 1'b0;
		{accWrite, accOp0, accOp1, accCrn, accCrm, accOp2, accWdata} = '0;
	end
	// One access, held over one rising edge; fields inverted once released
	task go(input logic w, input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2,
		input logic [63:0] wd);
		@(negedge clk);
		{accOp0, accOp1} = {2'h2, 3'h0};
		{accWrite, accCrn, accCrm, accOp2, accWdata} = {w, crn, crm, op2, wd};
		accValid = 1'b1;
		@(negedge clk);
		accValid = 1'b0;
		{accWrite, accCrn, accCrm, accOp2, accWdata} = ~{w, crn, crm, op2, wd};
	endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Testbench: status reads, breakpoint control traffic, external view, linking.
// Assumes the core model drives the access port.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk, rst_n, l2e, hl3, fta, frt, l3t, hlt, sdd, eie, ew, hvm, gtg;
	logic [1:0]  lvl, pr;
	logic [3:0]  ei, mi;
	logic [31:0] ewd, vc, vc2, c1, c2;
	logic [15:0] vv, vm;
	logic [63:0] e;
	logic [31:0] r;
	wire         accValid, accWrite, accDone, ctxMatch, lsv;
	wire [1:0]   accOp0, accResp;
	wire [2:0]   accOp1, accOp2;
	wire [3:0]   accCrn, accCrm, ls;
	wire [5:0]   accClass;
	wire [31:0]  erd;
	wire [63:0]  accWdata, accRdata;
	integer      bad_count, checks_done, seed, i, n;
	dabc_core_model i_dabc_core_model (.clk(clk), .accValid(accValid), .accWrite(accWrite), .accOp0(accOp0),
		.accOp1(accOp1), .accCrn(accCrn), .accCrm(accCrm), .accOp2(accOp2), .accWdata(accWdata));
	dabc_debug_auth_bkpt #(.NUM_BKPT(12)) i_dabc_debug_auth_bkpt (.clk(clk), .rst_n(rst_n),
		.accValid(accValid), .accWrite(accWrite), .accOp0(accOp0), .accOp1(accOp1), .accCrn(accCrn),
		.accCrm(accCrm), .accOp2(accOp2), .accWdata(accWdata), .curLevel(lvl), .level2Enabled(l2e),
		.haveLevel3(hl3), .fine_trap_allow(fta), .level2_fine_read_trap(frt), .level2_debug_trap_pair(pr),
		.level3_debug_access_trap(l3t), .coreHalted(hlt), .secure_debug_disabled(sdd), .extInvasiveEnabled(eie),
		.extWrite(ew), .extIndex(ei), .extWdata(ewd), .matchIndex(mi), .valueCtx(vc), .valueCtx2(vc2),
		.valueVm(vv), .level1_context_reg(c1), .level2_context_reg(c2), .stage2_vm_tag(vm), .host_virt_mode(hvm),
		.guest_trap_general(gtg), .accDone(accDone), .accResp(accResp), .accClass(accClass), .accRdata(accRdata),
		.extRdata(erd), .ctxMatch(ctxMatch), .linkedSel(ls), .linkedSelValid(lsv));
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp)
			bad_count++;
		if (got !== exp)
			$display("ERROR %0t got %h expected %h", $time, got, exp);
	endtask
	task close_out;
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One access with a bounded wait for its answer
	task acc(input logic w, input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2,
		input logic [63:0] wd);
		i_dabc_core_model.go(w, crn, crm, op2, wd);
		n = 0;
		while (accDone !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 4)
			bad_count++;
		if (n == 4)
			close_out;
	endtask
	// Expected status read answer
	function logic [1:0] aexp();
		if (lvl == 2'h0)
			return 2'h1;
		if (hlt && sdd && l3t && (hl3 || lvl == 2'h3))
			return 2'h1;
		if (lvl == 2'h1 && l2e && (((hl3 || fta) && frt) || pr != 2'h0))
			return 2'h2;
		if (lvl != 2'h3 && hl3 && l3t)
			return 2'h3;
		return 2'h0;
	endfunction
	// Expected context hit of an enabled breakpoint of kind kd
	function logic cexp(input logic [3:0] kd);
		logic u2;
		u2 = hvm && (lvl == 2'h2 || (lvl == 2'h0 && gtg));
		case (kd)
			4'h2: return u2 ? vc == c2 : vc == c1;
			4'h6: return vc == c1;
			4'h8: return vv == vm;
			4'hA: return vv == vm && vc == c1;
			4'hC: return vc2 == c2;
			4'hE: return vc == c1 && vc2 == c2;
			default: return 1'b0;
		endcase
	endfunction
	// Main sequence
	initial begin
		seed = 32'h158B;
		bad_count = 0;
		checks_done = 0;
		rst_n = 1'b0;
		{l2e, hl3, fta, frt, l3t, hlt, sdd, eie, ew, hvm, gtg, lvl, pr, ei, mi, ewd, vc, vc2, c1, c2, vv, vm} = '0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		for (i = 0; i < 60; i++) begin
			@(negedge clk);
			{l2e, hl3, fta, frt, l3t, hlt, sdd, eie, lvl, pr} = 12'($random(seed));
			acc(1'b0, 4'h7, 4'hE, 3'h6, 64'h0);
			e = aexp();
			chk(accResp, e);
			chk(accClass, e[1] ? 64'h18 : 64'h0);
			chk(accRdata, e == 0 ? {62'h0, 1'b1, eie} : 64'h0);
		end
		@(negedge clk);
		lvl = 2'h3;
		l3t = 1'b0;
		acc(1'b1, 4'h7, 4'hE, 3'h6, 64'h3);
		chk(accResp, 64'h1);
		for (i = 0; i < 16; i++) begin
			e = {$random(seed), $random(seed)};
			e[23:20] = i[3:0];
			acc(1'b1, 4'h0, 4'(i % 12), 3'h5, e);
			acc(1'b0, 4'h0, 4'(i % 12), 3'h5, 64'h0);
			e = e & 64'h20FFE1E7;
			if (i > 1)
				e[8:5] = 4'hF;
			chk(accRdata, e);
			acc(i[0], 4'h0, 4'(12 + i % 4), 3'h5, 64'h0);
			chk(accResp, 64'h1);
		end
		@(negedge clk);
		{ew, ei, ewd} = {1'b1, 4'h3, 32'($random(seed)) & 32'hFF0FFFFF};
		@(negedge clk);
		ew = 1'b0;
		@(negedge clk);
		chk(erd, ewd & 32'h20FFE1E7);
		acc(1'b0, 4'h0, 4'h3, 3'h5, 64'h0);
		chk(accRdata, ewd & 32'h20FFE1E7);
		{hvm, gtg, vc2, vv, vm, c2} = {$random(seed), $random(seed), $random(seed), $random(seed)};
		for (i = 0; i < 4; i++) begin
			acc(1'b1, 4'h0, 4'h2, 3'h5, {i[1] ? 64'h006001E0 : 64'h001501E0} | i[0]);
			@(negedge clk);
			{mi, vc, c1} = {4'h2, 32'h5A5A0000 + i, 32'h5A5A0003};
			@(negedge clk);
			chk(lsv, i == 1);
			chk(ls & {4{lsv}}, i == 1 ? 64'h5 : 64'h0);
			chk(ctxMatch, i == 3 ? 64'h1 : 64'h0);
		end
		// Every context kind, enabled, with random equal or differing context values
		for (i = 0; i < 24; i++) begin
			lvl = 2'h3;
			e = 64'h1E1;
			e[23:20] = 4'((i % 8) * 2);
			acc(1'b1, 4'h0, 4'h4, 3'h5, e);
			r = $random(seed);
			{hvm, gtg, lvl, mi} = {r[3:0], 4'h4};
			{vc, vc2, vv} = {$random(seed), $random(seed), 16'($random(seed))};
			c1 = r[4] ? vc : ~vc;
			c2 = r[5] ? vc2 : vc;
			vm = r[6] ? vv : ~vv;
			@(negedge clk);
			chk(ctxMatch, cexp(e[23:20]));
		end
		close_out;
	end
endmodule
`default_nettype wire

/* File: rtl/dabc_bkpt_match.v */
// One breakpoint's context comparison, per breakpoint kind.
// Assumes context and VM tag inputs are stable in the cycle they are used.
`include "dabc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module dabc_bkpt_match (
	input  wire [31:0] ctrl,
	input  wire [31:0] valueCtx,
	input  wire [31:0] valueCtx2,
	input  wire [15:0] valueVm,
	input  wire [31:0] level1Ctx,
	input  wire [31:0] level2Ctx,
	input  wire [15:0] vmTag,
	input  wire        useLevel2,
	output reg         ctxHit
);
	wire [3:0] kind = ctrl[`DABC_F_KIND_LO+3:`DABC_F_KIND_LO];
	wire       eq1  = (valueCtx == level1Ctx);
	wire       eq2  = (valueCtx2 == level2Ctx);
	wire       eqV  = (valueVm == vmTag);
	// Comparison chosen by kind, link bit dropped
	always @* begin
		case (kind[3:1])
			`DABC_K_CTX:   ctxHit = useLevel2 ? (valueCtx == level2Ctx) : eq1;
			`DABC_K_CTX1:  ctxHit = eq1;
			`DABC_K_VM:    ctxHit = eqV;
			`DABC_K_VMCTX: ctxHit = eqV & eq1;
			`DABC_K_CTX2:  ctxHit = eq2;
			`DABC_K_FULL:  ctxHit = eq1 & eq2;
			default:       ctxHit = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

/* File: rtl/dabc_debug_auth_bkpt.v */
// Debug authentication status read path and breakpoint control registers.
// Assumes the core presents one decoded system-register access per valid cycle.
`include "dabc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module dabc_debug_auth_bkpt #(
	parameter NUM_BKPT     = 16,
	parameter HAVE_REALM   = 1,
	parameter HAVE_HW32    = 1,
	parameter NSI_PRESENT  = 1,
	parameter L3_PRIORITY  = 1
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        accValid,
	input  wire        accWrite,
	input  wire [1:0]  accOp0,
	input  wire [2:0]  accOp1,
	input  wire [3:0]  accCrn,
	input  wire [3:0]  accCrm,
	input  wire [2:0]  accOp2,
	input  wire [63:0] accWdata,
	input  wire [1:0]  curLevel,
	input  wire        level2Enabled,
	input  wire        haveLevel3,
	input  wire        fine_trap_allow,
	input  wire        level2_fine_read_trap,
	input  wire [1:0]  level2_debug_trap_pair,
	input  wire        level3_debug_access_trap,
	input  wire        coreHalted,
	input  wire        secure_debug_disabled,
	input  wire        extInvasiveEnabled,
	input  wire        extWrite,
	input  wire [3:0]  extIndex,
	input  wire [31:0] extWdata,
	input  wire [3:0]  matchIndex,
	input  wire [31:0] valueCtx,
	input  wire [31:0] valueCtx2,
	input  wire [15:0] valueVm,
	input  wire [31:0] level1_context_reg,
	input  wire [31:0] level2_context_reg,
	input  wire [15:0] stage2_vm_tag,
	input  wire        host_virt_mode,
	input  wire        guest_trap_general,
	output reg         accDone,
	output reg  [1:0]  accResp,
	output reg  [5:0]  accClass,
	output reg  [63:0] accRdata,
	output reg  [31:0] extRdata,
	output reg         ctxMatch,
	output reg  [3:0]  linkedSel,
	output reg         linkedSelValid
);
	// Control storage; one 32-bit word per breakpoint, upper half reserved
	reg  [31:0] bcr [0:15];
	reg  [31:0] next_bcrWord;
	reg  [1:0]  next_resp;
	reg  [63:0] next_rdata;
	reg  [1:0]  nsiField;
	integer     i;

	wire isAuth = (accOp0 == `DABC_OP0) && (accOp1 == `DABC_OP1) && (accCrn == `DABC_AUTH_CRN)
	              && (accCrm == `DABC_AUTH_CRM) && (accOp2 == `DABC_AUTH_OP2);
	wire isBcr  = (accOp0 == `DABC_OP0) && (accOp1 == `DABC_OP1) && (accCrn == `DABC_BCR_CRN)
	              && (accOp2 == `DABC_BCR_OP2);
	wire bcrImpl = ({28'h0, accCrm} < NUM_BKPT);
	wire haltSdd = coreHalted && secure_debug_disabled && level3_debug_access_trap && haveLevel3;
	wire l3Trap  = haveLevel3 && level3_debug_access_trap;

	// Field values seen by reads: reserved cleared, optional fields fixed
	function [31:0] dabc_view;
		input [31:0] w;
		reg   [31:0] v;
		begin
			v = w & `DABC_BCR_MASK;
			if (HAVE_REALM == 0) begin
				v[`DABC_F_SSE] = 1'b0;
			end
			if ((HAVE_HW32 == 0) || (w[`DABC_F_KIND_LO+3:`DABC_F_KIND_LO] != 4'h0 &&
			    w[`DABC_F_KIND_LO+3:`DABC_F_KIND_LO] != 4'h1)) begin
				v[`DABC_F_HW_LO+3:`DABC_F_HW_LO] = `DABC_HW_WORD;
			end
			dabc_view = v;
		end
	endfunction

	// Non-secure invasive authentication field
	always @* begin
		if (NSI_PRESENT == 0) begin
			nsiField = `DABC_NSI_NONE;
		end else if (extInvasiveEnabled) begin
			nsiField = `DABC_NSI_ON;
		end else begin
			nsiField = `DABC_NSI_OFF;
		end
	end

	// Ordered undefined and trap checks for each access
	always @* begin
		next_resp    = `DABC_RESP_UNDEF;
		next_rdata   = 64'h0;
		next_bcrWord = (accCrm < 4'hF) ? bcr[accCrm] : bcr[4'hF];
		if (isAuth && !accWrite) begin
			case (curLevel)
				2'h0: next_resp = `DABC_RESP_UNDEF;
				2'h1: begin
					if (L3_PRIORITY != 0 && haltSdd) begin
						next_resp = `DABC_RESP_UNDEF;
					end else if (level2Enabled && (haveLevel3 || fine_trap_allow) && level2_fine_read_trap) begin
						next_resp = `DABC_RESP_TRAP2;
					end else if (level2Enabled && (level2_debug_trap_pair != 2'h0)) begin
						next_resp = `DABC_RESP_TRAP2;
					end else if (l3Trap) begin
						next_resp = (coreHalted && secure_debug_disabled) ? `DABC_RESP_UNDEF : `DABC_RESP_TRAP3;
					end else begin
						next_resp = `DABC_RESP_OK;
					end
				end
				2'h2: begin
					if (l3Trap) begin
						next_resp = (coreHalted && secure_debug_disabled) ? `DABC_RESP_UNDEF : `DABC_RESP_TRAP3;
					end else begin
						next_resp = `DABC_RESP_OK;
					end
				end
				default: begin
					// Halted undefined case at level 3 needs no level-3 presence input while L3_PRIORITY is set, else haveLevel3
					if (coreHalted && secure_debug_disabled && level3_debug_access_trap &&
					    (L3_PRIORITY != 0 || haveLevel3)) begin
						next_resp = `DABC_RESP_UNDEF;
					end else begin
						next_resp = `DABC_RESP_OK;
					end
				end
			endcase
			if (next_resp == `DABC_RESP_OK) begin
				next_rdata = {62'h0, nsiField};
			end
		end else if (isBcr && bcrImpl && curLevel != 2'h0) begin
			if (l3Trap && curLevel != 2'h3) begin
				next_resp = (coreHalted && secure_debug_disabled) ? `DABC_RESP_UNDEF : `DABC_RESP_TRAP3;
			end else begin
				next_resp = `DABC_RESP_OK;
			end
			if (next_resp == `DABC_RESP_OK && !accWrite) begin
				next_rdata = {32'h0, dabc_view(next_bcrWord)};
			end
		end
	end

	// Access answer, one cycle after the request
	always @(posedge clk) begin
		if (!rst_n) begin
			accDone  <= 1'b0;
			accResp  <= `DABC_RESP_OK;
			accClass <= 6'h0;
			accRdata <= 64'h0;
		end else begin
			accDone  <= accValid;
			accResp  <= accValid ? next_resp : `DABC_RESP_OK;
			accClass <= (accValid && next_resp[1]) ? `DABC_EC_SYSREG : 6'h0;
			accRdata <= accValid ? next_rdata : 64'h0;
		end
	end

	// Control storage; core write wins over external write to same word.
	// Reset clears storage only to keep simulation defined; software must program it.
	always @(posedge clk) begin
		if (!rst_n) begin
			for (i = 0; i < 16; i = i + 1) begin
				bcr[i] <= 32'h0;
			end
		end else begin
			for (i = 0; i < 16; i = i + 1) begin
				if (accValid && accWrite && isBcr && bcrImpl && curLevel != 2'h0 &&
				    !(l3Trap && curLevel != 2'h3) && accCrm == i[3:0]) begin
					bcr[i] <= accWdata[31:0] & `DABC_BCR_MASK;
				end else if (extWrite && extIndex == i[3:0] && i < NUM_BKPT) begin
					bcr[i] <= extWdata & `DABC_BCR_MASK;
				end
			end
		end
	end

	// Context comparison for the selected breakpoint
	wire [31:0] selWord = bcr[matchIndex];
	wire        selUseL2 = host_virt_mode && (curLevel == 2'h2 || (curLevel == 2'h0 && guest_trap_general));
	wire        selHit;
	wire [3:0]  selKind = selWord[`DABC_F_KIND_LO+3:`DABC_F_KIND_LO];

	dabc_bkpt_match u_match (
		.ctrl      (selWord),
		.valueCtx  (valueCtx),
		.valueCtx2 (valueCtx2),
		.valueVm   (valueVm),
		.level1Ctx (level1_context_reg),
		.level2Ctx (level2_context_reg),
		.vmTag     (stage2_vm_tag),
		.useLevel2 (selUseL2),
		.ctxHit    (selHit)
	);

	// Registered match and linked index outputs, plus external view
	always @(posedge clk) begin
		if (!rst_n) begin
			ctxMatch       <= 1'b0;
			linkedSel      <= 4'h0;
			linkedSelValid <= 1'b0;
			extRdata       <= 32'h0;
		end else begin
			ctxMatch       <= selHit && selWord[`DABC_F_ENABLE] && ({28'h0, matchIndex} < NUM_BKPT);
			linkedSel      <= selWord[`DABC_F_LINK_LO+3:`DABC_F_LINK_LO];
			linkedSelValid <= selWord[`DABC_F_ENABLE] && (selKind == 4'h1);
			extRdata       <= dabc_view(bcr[extIndex]);
		end
	end
endmodule
`default_nettype wire

/* File: rtl/dabc_regs.vh */
// Constants for the debug authentication status and breakpoint control block.
// Assumes the core decodes system-register instructions into the access fields given here.
// Functional notes
// - Non-secure invasive field bits 1:0 reads 00, 10 or 11 per implementation and enable.
// - Status register is read with op0 10, op1 000, CRn 0111, CRm 1110, op2 110.
// - Status read at exception level 0 is an undefined instruction.
// - Level 1 read traps to level 2, class 18h, when fine-grained read trap active.
// - Level 1 read traps to level 2 when either level-2 debug trap control set.
// - Levels 1-2 trap to level 3 when its trap set, undefined if halted without secure debug.
// - Optional priority makes halted secure-disabled access undefined before level-2 checks.
// - Level 3 read returns status unless halted secure-debug-disabled undefined case applies.
// - Sixteen breakpoints with 64-bit control; unimplemented breakpoint access is undefined.
// - Low 32 control bits are one storage shared by all register views.
// - Bit 29 exists only with realm extension, otherwise reads zero.
// - Kind field 23:20; 0000 unlinked address, odd codes are linked forms.
// - Kind 0010 compares level-2 context in host mode at level 2 or trapped level 0.
// - Kind 1000 compares VM tag; 1010 needs VM tag and level-1 context.
// - Kind 0110 level-1 context, 1100 level-2 context, 1110 both.
// - Unlisted kind codes are reserved and never match.
// - Linked index 19:16 selects context breakpoint for linked address kinds only.
// - Linked index ignored while breakpoint enable bit is zero.
// - Security-state filter 15:14 qualifies events with other filter fields.
// - Higher-level view bit 13 chooses debug perspective for events.
// - Cold reset leaves fields unknown; software programs before enabling. Reset here clears every control word to zero.
// - Halfword select 8:5 present when 32-bit level 0 supported.
// - Address halfword select 0011, 1100, 1111; context kinds read ones. Address kinds here store and read back any 4-bit value.
`ifndef DABC_REGS_VH
`define DABC_REGS_VH
`define DABC_OP0         2'h2
`define DABC_OP1         3'h0
`define DABC_AUTH_CRN    4'h7
`define DABC_AUTH_CRM    4'hE
`define DABC_AUTH_OP2    3'h6
`define DABC_BCR_CRN     4'h0
`define DABC_BCR_OP2     3'h5
`define DABC_EC_SYSREG   6'h18
`define DABC_NSI_NONE    2'h0
`define DABC_NSI_OFF     2'h2
`define DABC_NSI_ON      2'h3
`define DABC_F_ENABLE    0
`define DABC_F_PRIV_LO   1
`define DABC_F_HW_LO     5
`define DABC_F_HLV       13
`define DABC_F_SSF_LO    14
`define DABC_F_LINK_LO   16
`define DABC_F_KIND_LO   20
`define DABC_F_SSE       29
`define DABC_BCR_MASK    32'h20FFE1E7
`define DABC_HW_BASE     4'h3
`define DABC_HW_PLUS2    4'hC
`define DABC_HW_WORD     4'hF
`define DABC_K_ADDR      3'h0
`define DABC_K_CTX       3'h1
`define DABC_K_CTX1      3'h3
`define DABC_K_VM        3'h4
`define DABC_K_VMCTX     3'h5
`define DABC_K_CTX2      3'h6
`define DABC_K_FULL      3'h7
`define DABC_RESP_OK     2'h0
`define DABC_RESP_UNDEF  2'h1
`define DABC_RESP_TRAP2  2'h2
`define DABC_RESP_TRAP3  2'h3
`endif
